// *** core/pac_cmd_interp.v ***
// Parameter access command interpreter: decodes nine-byte command frames,
// reads and writes axis and global parameters, and answers with a reply frame.
// Assumes bytes arrive as one-cycle strobes and the host drains replies byte by byte.
`timescale 1ns/1ps
`default_nettype none
`include "pac_defs.vh"
module pac_cmd_interp #(
	parameter RESTORE_WORDS = 256
) (
	input wire clk_in,
	input wire rst_in,
	// Command byte stream
	input wire cmd_valid_in,
	input wire [7:0] cmd_byte_in,
	input wire program_mode_in,
	input wire restore_req_in,
	output wire cmd_ready_out,
	// Reply byte stream
	output reg reply_valid_out,
	output reg [7:0] reply_byte_out,
	input wire reply_ready_in,
	// Nonvolatile store port
	output reg nv_write_out,
	output reg [9:0] nv_addr_out,
	output reg [31:0] nv_data_out,
	input wire nv_done_in,
	output reg nv_read_out,
	input wire nv_rdata_valid_in,
	input wire [31:0] nv_rdata_in,
	// Accumulator
	output reg [31:0] accu_out,
	output reg busy_out
);
	// ==========================================
	// States
	localparam ST_RX = 3'h0;
	localparam ST_EXEC = 3'h1;
	localparam ST_READ = 3'h2;
	localparam ST_NV = 3'h3;
	localparam ST_TX = 3'h4;
	localparam ST_RESTORE = 3'h5;
	localparam ST_RWAIT = 3'h6;

	reg [2:0] state_q;
	reg [3:0] idx_q;
	reg [7:0] instr_q, type_q, bank_q, sum_q;
	reg [31:0] value_q;
	reg csum_bad_q, from_prog_q;
	reg [7:0] status_q;
	reg [31:0] rvalue_q;
	reg [8:0] rst_idx_q;
	reg mem_we;
	reg [9:0] mem_waddr, mem_raddr;
	reg [31:0] mem_wdata;
	wire [31:0] mem_rdata;

	// Address map: axis in slot 1, banks 0/2/3 in slots 0/2/3
	function [9:0] gaddr;
		input [7:0] bank;
		input [7:0] typ;
		begin
			gaddr = {bank[1:0], typ};
		end
	endfunction

	// Bank legal only when 0, 2 or 3
	function bank_ok;
		input [7:0] bank;
		begin
			bank_ok = (bank == `PAC_BANK_SETTINGS) || (bank == `PAC_BANK_USER) ||
				(bank == `PAC_BANK_IRQ);
		end
	endfunction

	// Reply byte: address, module, status, instr, value MSB first, checksum
	function [7:0] reply_byte;
		input [3:0] i;
		input [7:0] st;
		input [7:0] ins;
		input [31:0] v;
		reg [7:0] s;
		begin
			s = `PAC_HOST_ADDR_RESET + `PAC_MODULE_ADDR_RESET + st + ins +
				v[31:24] + v[23:16] + v[15:8] + v[7:0];
			case (i)
				4'h0: reply_byte = `PAC_HOST_ADDR_RESET;
				4'h1: reply_byte = `PAC_MODULE_ADDR_RESET;
				4'h2: reply_byte = st;
				4'h3: reply_byte = ins;
				4'h4: reply_byte = v[31:24];
				4'h5: reply_byte = v[23:16];
				4'h6: reply_byte = v[15:8];
				4'h7: reply_byte = v[7:0];
				default: reply_byte = s;
			endcase
		end
	endfunction

	pac_param_mem #(.AW(10), .DW(32)) u_mem (
		.clk_in(clk_in),
		.wr_en_in(mem_we),
		.wr_addr_in(mem_waddr),
		.wr_data_in(mem_wdata),
		.rd_addr_in(mem_raddr),
		.rd_data_out(mem_rdata)
	);

	// Axis parameters live only in this volatile memory, never sent to the store
	always @* begin
		mem_we = 1'b0;
		mem_waddr = 10'h000;
		mem_wdata = 32'h00000000;
		mem_raddr = (instr_q == `PAC_OP_GET_AXIS) ? {2'b01, type_q} : gaddr(bank_q, type_q);
		if (state_q == ST_EXEC && !csum_bad_q) begin
			if (instr_q == `PAC_OP_SET_AXIS) begin
				mem_we = 1'b1;
				mem_waddr = {2'b01, type_q};
				mem_wdata = value_q;
			end else if (instr_q == `PAC_OP_SET_GLOBAL && bank_ok(bank_q)) begin
				mem_we = 1'b1;
				mem_waddr = gaddr(bank_q, type_q);
				mem_wdata = value_q;
			end
		end else if (state_q == ST_RWAIT && nv_rdata_valid_in) begin
			mem_we = 1'b1;
			mem_waddr = {2'b10, rst_idx_q[7:0]};
			mem_wdata = nv_rdata_in;
		end
	end

	assign cmd_ready_out = (state_q == ST_RX);

	// ==========================================
	// Main sequencer
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_RESTORE;
			idx_q <= 4'h0;
			instr_q <= 8'h00;
			type_q <= 8'h00;
			bank_q <= 8'h00;
			sum_q <= 8'h00;
			value_q <= `PAC_RESET_WORD;
			csum_bad_q <= 1'b0;
			from_prog_q <= 1'b0;
			status_q <= 8'h00;
			rvalue_q <= `PAC_RESET_WORD;
			rst_idx_q <= 9'h000;
			reply_valid_out <= 1'b0;
			reply_byte_out <= 8'h00;
			nv_write_out <= 1'b0;
			nv_read_out <= 1'b0;
			nv_addr_out <= 10'h000;
			nv_data_out <= `PAC_RESET_WORD;
			accu_out <= `PAC_RESET_WORD;
			busy_out <= 1'b1;
		end else begin
			nv_write_out <= 1'b0;
			nv_read_out <= 1'b0;
			case (state_q)
				// Restore of user variables at power-on or on request, one word at a time
				ST_RESTORE: begin
					if (rst_idx_q == RESTORE_WORDS[8:0]) begin
						state_q <= ST_RX;
						busy_out <= 1'b0;
					end else begin
						nv_read_out <= 1'b1;
						nv_addr_out <= {2'b10, rst_idx_q[7:0]};
						state_q <= ST_RWAIT;
					end
				end
				ST_RWAIT: begin
					if (nv_rdata_valid_in) begin
						rst_idx_q <= rst_idx_q + 9'h001;
						state_q <= ST_RESTORE;
					end
				end
				// Collect nine bytes, summing the first eight
				ST_RX: begin
					if (restore_req_in) begin
						rst_idx_q <= 9'h000;
						busy_out <= 1'b1;
						state_q <= ST_RESTORE;
					end else if (cmd_valid_in) begin
						case (idx_q)
							`PAC_IDX_INSTR: instr_q <= cmd_byte_in;
							`PAC_IDX_TYPE: type_q <= cmd_byte_in;
							`PAC_IDX_BANK: bank_q <= cmd_byte_in;
							4'h4, 4'h5, 4'h6, 4'h7: value_q <= {value_q[23:0], cmd_byte_in};
							default: ;
						endcase
						if (idx_q == `PAC_IDX_ADDR) begin
							sum_q <= cmd_byte_in;
							from_prog_q <= program_mode_in;
						end else if (idx_q != `PAC_IDX_CSUM) begin
							sum_q <= sum_q + cmd_byte_in;
						end
						if (idx_q == `PAC_IDX_CSUM) begin
							csum_bad_q <= (sum_q != cmd_byte_in);
							idx_q <= 4'h0;
							busy_out <= 1'b1;
							state_q <= ST_EXEC;
						end else begin
							idx_q <= idx_q + 4'h1;
						end
					end
				end
				// Decide the status; writes happen combinationally this cycle
				ST_EXEC: begin
					rvalue_q <= `PAC_RESET_WORD;
					status_q <= `PAC_ST_OK;
					state_q <= ST_TX;
					if (csum_bad_q) begin
						status_q <= `PAC_ST_BAD_CHECKSUM;
					end else begin
						case (instr_q)
							`PAC_OP_SET_AXIS: ;
							`PAC_OP_GET_AXIS: state_q <= ST_READ;
							`PAC_OP_SET_GLOBAL, `PAC_OP_GET_GLOBAL: begin
								if (!bank_ok(bank_q)) begin
									status_q <= `PAC_ST_BAD_VALUE;
								end else if (instr_q == `PAC_OP_GET_GLOBAL) begin
									state_q <= ST_READ;
								end else if (bank_q == `PAC_BANK_SETTINGS) begin
									nv_write_out <= 1'b1;
									nv_addr_out <= gaddr(bank_q, type_q);
									nv_data_out <= value_q;
									state_q <= ST_NV;
								end
							end
							`PAC_OP_STORE_GLOBAL: begin
								if (bank_ok(bank_q)) begin
									state_q <= ST_READ;
								end else begin
									status_q <= `PAC_ST_BAD_VALUE;
								end
							end
							default: status_q <= `PAC_ST_BAD_CMD;
						endcase
					end
				end
				// Registered memory data is ready now
				ST_READ: begin
					if (instr_q == `PAC_OP_STORE_GLOBAL) begin
						nv_write_out <= 1'b1;
						nv_addr_out <= gaddr(bank_q, type_q);
						nv_data_out <= mem_rdata;
						state_q <= ST_NV;
					end else begin
						rvalue_q <= mem_rdata;
						if (instr_q == `PAC_OP_GET_GLOBAL || from_prog_q) begin
							accu_out <= mem_rdata;
						end
						// Direct-mode axis read leaves the accumulator alone
						state_q <= ST_TX;
					end
				end
				// Hold the reply until the store reports completion
				ST_NV: begin
					if (nv_done_in) begin
						state_q <= ST_TX;
					end
				end
				// Send one reply frame byte by byte
				ST_TX: begin
					if (!reply_valid_out) begin
						reply_valid_out <= 1'b1;
						reply_byte_out <= reply_byte(idx_q, status_q, instr_q, rvalue_q);
					end else if (reply_ready_in) begin
						if (idx_q == `PAC_IDX_CSUM) begin
							reply_valid_out <= 1'b0;
							idx_q <= 4'h0;
							busy_out <= 1'b0;
							state_q <= ST_RX;
						end else begin
							idx_q <= idx_q + 4'h1;
							reply_byte_out <= reply_byte(idx_q + 4'h1, status_q, instr_q, rvalue_q);
						end
					end
				end
				default: state_q <= ST_RX;
			endcase
		end
	end
endmodule // pac_cmd_interp
`default_nettype wire

// *** core/pac_defs.vh ***
// Constants for the parameter access command interpreter.
// Assumes inclusion by bare name from core/ design files.
`ifndef PAC_DEFS_VH
`define PAC_DEFS_VH
// Instruction numbers
`define PAC_OP_SET_AXIS 8'h05
`define PAC_OP_GET_AXIS 8'h06
`define PAC_OP_SET_GLOBAL 8'h09
`define PAC_OP_GET_GLOBAL 8'h0A
`define PAC_OP_STORE_GLOBAL 8'h0B
// Banks
`define PAC_BANK_SETTINGS 8'h00
`define PAC_BANK_USER 8'h02
`define PAC_BANK_IRQ 8'h03
// Reply status codes
`define PAC_ST_OK 8'h64
`define PAC_ST_BAD_CHECKSUM 8'h01
`define PAC_ST_BAD_CMD 8'h02
`define PAC_ST_BAD_TYPE 8'h03
`define PAC_ST_BAD_VALUE 8'h04
// Frame layout
`define PAC_FRAME_BYTES 4'h9
`define PAC_IDX_ADDR 4'h0
`define PAC_IDX_INSTR 4'h1
`define PAC_IDX_TYPE 4'h2
`define PAC_IDX_BANK 4'h3
`define PAC_IDX_CSUM 4'h8
// Reset values
`define PAC_RESET_WORD 32'h00000000
`define PAC_HOST_ADDR_RESET 8'h02
`define PAC_MODULE_ADDR_RESET 8'h01
`endif

// *** core/pac_param_mem.v ***
// Parameter storage: one word memory, registered read data.
// Assumes a single clock; a read of the address being written returns the old word.
`timescale 1ns/1ps
`default_nettype none
module pac_param_mem #(
	parameter AW = 10,
	parameter DW = 32
) (
	input wire clk_in,
	input wire wr_en_in,
	input wire [AW-1:0] wr_addr_in,
	input wire [DW-1:0] wr_data_in,
	input wire [AW-1:0] rd_addr_in,
	output reg [DW-1:0] rd_data_out
);
	// ==========================================
	// Storage
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Write port and registered read port; no reset so it maps to RAM
	always @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule // pac_param_mem
`default_nettype wire

// *** test/pac_cmd_props.sv ***
// Port checker for the parameter access command interpreter.
// Bound onto pac_cmd_interp; one clock, async reset active high.
`timescale 1ns/1ps
`default_nettype none
module pac_cmd_props (
	input wire clk_in,
	input wire rst_in,
	input wire cmd_ready_out,
	input wire reply_valid_out,
	input wire [7:0] reply_byte_out,
	input wire reply_ready_in,
	input wire nv_write_out,
	input wire nv_read_out,
	input wire nv_done_in,
	input wire [31:0] accu_out
);
	// ==========
	// Port relations
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	reply_hold_a: assert property (
		reply_valid_out && !reply_ready_in |=> reply_valid_out && $stable(reply_byte_out))
		else $error("reply byte moved while stalled");
	reply_head_a: assert property (
		$rose(reply_valid_out) |-> reply_byte_out == 8'h02)
		else $error("reply does not start with host address");
	recv_quiet_a: assert property (
		cmd_ready_out |-> !reply_valid_out)
		else $error("reply while receiving");
	recv_nostore_a: assert property (
		cmd_ready_out |-> !nv_write_out)
		else $error("store write while receiving");
	store_pulse_a: assert property (
		nv_write_out |=> !nv_write_out [*2])
		else $error("store write longer than one cycle");
	fetch_pulse_a: assert property (
		nv_read_out |=> !nv_read_out)
		else $error("restore read longer than one cycle");
	accu_idle_a: assert property (
		cmd_ready_out |-> $stable(accu_out))
		else $error("accumulator moved while receiving");
	store_reply_a: assert property (
		nv_done_in |-> ##[1:8] reply_valid_out)
		else $error("no reply after store finished");
endmodule // pac_cmd_props
bind pac_cmd_interp pac_cmd_props u_pac_cmd_props (.clk_in, .rst_in, .cmd_ready_out,
	.reply_valid_out, .reply_byte_out, .reply_ready_in, .nv_write_out, .nv_read_out,
	.nv_done_in, .accu_out);
`default_nettype wire

// *** test/pac_nv_model.sv ***
// Nonvolatile store model on the far side of the interpreter's store port.
// Assumes one request at a time; lat_in (1..15) sets the answer delay.
`timescale 1ns/1ps
`default_nettype none
module pac_nv_model (
	input wire clk_in,
	input wire rst_in,
	input wire [3:0] lat_in,
	input wire nv_write_in,
	input wire nv_read_in,
	input wire [9:0] nv_addr_in,
	input wire [31:0] nv_data_in,
	output reg nv_done_out,
	output reg nv_rdata_valid_out,
	output reg [31:0] nv_rdata_out
);
	reg [31:0] mem [0:1023];
	reg [9:0] addr_q;
	reg [3:0] cnt_q;
	reg wr_q;
	integer wr_cnt_q;
	// One user word preset so the power-on restore fetches a known value
	initial mem[10'h201] = 32'hA5C30F01;
	// ==========
	// Requests; read data toggles when idle so a stale sample shows
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 4'h0;
			wr_cnt_q <= 0;
			nv_done_out <= 1'b0;
			nv_rdata_valid_out <= 1'b0;
			nv_rdata_out <= 32'h0;
		end else begin
			nv_done_out <= wr_q && cnt_q == 4'h1;
			nv_rdata_valid_out <= !wr_q && cnt_q == 4'h1;
			nv_rdata_out <= (cnt_q == 4'h1) ? mem[addr_q] : ~nv_rdata_out;
			cnt_q <= (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
			if (nv_write_in || nv_read_in) begin
				cnt_q <= lat_in;
				wr_q <= nv_write_in;
				addr_q <= nv_addr_in;
			end
			if (nv_write_in) begin
				mem[nv_addr_in] <= nv_data_in;
				wr_cnt_q <= wr_cnt_q + 1;
			end
		end
	end
endmodule // pac_nv_model
`default_nettype wire

// *** test/tb_pac_cmd_interp.sv ***
// Self-checking bench for the parameter access command interpreter.
// Assumes the store model answers every store and restore request.
`timescale 1ns/1ps
`default_nettype none
module tb_pac_cmd_interp;
	reg clk_in = 1'b0;
	reg rst_in = 1'b1;
	reg cmd_valid_in = 1'b0;
	reg [7:0] cmd_byte_in = 8'h00;
	reg program_mode_in = 1'b0;
	reg restore_req_in = 1'b0;
	reg reply_ready_in = 1'b0;
	reg [3:0] lat = 4'h1;
	wire cmd_ready_out, reply_valid_out, nv_write_out, nv_done_in;
	wire nv_read_out, nv_rdata_valid_in, busy_out;
	wire [7:0] reply_byte_out;
	wire [9:0] nv_addr_out;
	wire [31:0] nv_data_out, nv_rdata_in, accu_out;
	integer failures = 0;
	integer checks = 0;
	integer k;
	integer w;
	reg [31:0] acc;
	// 100 MHz clock
	always #5 clk_in = ~clk_in;
	// Short restore keeps the run brief
	pac_cmd_interp #(.RESTORE_WORDS(4)) u_pac_cmd_interp (.clk_in(clk_in), .rst_in(rst_in),
		.cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in),
		.program_mode_in(program_mode_in), .restore_req_in(restore_req_in),
		.cmd_ready_out(cmd_ready_out), .reply_valid_out(reply_valid_out),
		.reply_byte_out(reply_byte_out), .reply_ready_in(reply_ready_in),
		.nv_write_out(nv_write_out), .nv_addr_out(nv_addr_out), .nv_data_out(nv_data_out),
		.nv_done_in(nv_done_in), .nv_read_out(nv_read_out),
		.nv_rdata_valid_in(nv_rdata_valid_in), .nv_rdata_in(nv_rdata_in),
		.accu_out(accu_out), .busy_out(busy_out));
	pac_nv_model u_pac_nv_model (.clk_in(clk_in), .rst_in(rst_in), .lat_in(lat),
		.nv_write_in(nv_write_out), .nv_read_in(nv_read_out), .nv_addr_in(nv_addr_out),
		.nv_data_in(nv_data_out), .nv_done_out(nv_done_in),
		.nv_rdata_valid_out(nv_rdata_valid_in), .nv_rdata_out(nv_rdata_in));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks=%0d failures=%0d", checks, failures);
			if (failures == 0 && checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// A wait that ran out is a mismatch
	task halt;
		begin
			chk(32'h0, 32'h1);
			conclude;
		end
	endtask
	function [7:0] csum(input [71:0] f);
		integer i;
		begin
			csum = 8'h00;
			for (i = 1; i < 9; i = i + 1)
				csum = csum + f[8*i +: 8];
		end
	endfunction
	// ==========
	// One frame out, one reply in; the reply is stalled every other cycle
	task cmd(input [7:0] ins, typ, bank, input [31:0] val, input [7:0] cx, st,
		input [31:0] rv);
		reg [71:0] f;
		integer i;
		integer n;
		begin
			n = 0;
			while (cmd_ready_out !== 1'b1) begin
				@(negedge clk_in);
				n = n + 1;
				if (n > 2000)
					halt;
			end
			f = {8'h01, ins, typ, bank, val, 8'h00};
			f[7:0] = csum(f) ^ cx;
			for (i = 8; i >= 0; i = i - 1) begin
				@(negedge clk_in);
				cmd_valid_in = 1'b1;
				cmd_byte_in = f[8*i +: 8];
			end
			@(negedge clk_in);
			cmd_valid_in = 1'b0;
			f = {8'h02, 8'h01, st, ins, rv, 8'h00};
			f[7:0] = csum(f);
			i = 8;
			while (i >= 0) begin
				@(negedge clk_in);
				n = n + 1;
				if (n > 2000)
					halt;
				reply_ready_in = reply_valid_out & n[0];
				if (reply_ready_in) begin
					chk(reply_byte_out, f[8*i +: 8]);
					i = i - 1;
				end
			end
			@(negedge clk_in);
			reply_ready_in = 1'b0;
			chk({31'h0, reply_valid_out}, 32'h0);
			chk({31'h0, busy_out}, 32'h0);
		end
	endtask
	// ==========
	// Scenarios
	task t_restore;
		begin
			cmd(8'h0A, 8'h01, 8'h02, 32'h0, 8'h00, 8'h64, 32'hA5C30F01);
			chk(accu_out, 32'hA5C30F01);
		end
	endtask
	// Overwrite a user word, then ask for the restore again; the stored value returns
	task t_rerun;
		begin
			cmd(8'h09, 8'h01, 8'h02, 32'h12345678, 8'h00, 8'h64, 32'h0);
			restore_req_in = 1'b1;
			@(negedge clk_in);
			restore_req_in = 1'b0;
			chk({31'h0, busy_out}, 32'h1);
			chk({31'h0, cmd_ready_out}, 32'h0);
			cmd(8'h0A, 8'h01, 8'h02, 32'h0, 8'h00, 8'h64, 32'hA5C30F01);
			chk(accu_out, 32'hA5C30F01);
		end
	endtask
	task t_axis;
		begin
			w = u_pac_nv_model.wr_cnt_q;
			acc = accu_out;
			cmd(8'h05, 8'h04, 8'h00, 32'h0000C800, 8'h00, 8'h64, 32'h0);
			cmd(8'h06, 8'h04, 8'h00, 32'h0, 8'h00, 8'h64, 32'h0000C800);
			chk(accu_out, acc);
			chk(u_pac_nv_model.wr_cnt_q - w, 32'h0);
			program_mode_in = 1'b1;
			cmd(8'h06, 8'h04, 8'h00, 32'h0, 8'h00, 8'h64, 32'h0000C800);
			program_mode_in = 1'b0;
			chk(accu_out, 32'h0000C800);
		end
	endtask
	// Banks 3, 2, 0 in turn; only bank 0 reaches the store
	task t_global;
		reg [7:0] b;
		begin
			for (k = 0; k < 3; k = k + 1) begin
				b = k[0] ? 8'h02 : (k == 0 ? 8'h03 : 8'h00);
				w = u_pac_nv_model.wr_cnt_q;
				cmd(8'h09, 8'h07, b, {8'h5A, b, 16'hC3E1}, 8'h00, 8'h64, 32'h0);
				chk(u_pac_nv_model.wr_cnt_q - w, {31'h0, b == 8'h00});
				cmd(8'h0A, 8'h07, b, 32'hFFFFFFFF, 8'h00, 8'h64, {8'h5A, b, 16'hC3E1});
				chk(accu_out, {8'h5A, b, 16'hC3E1});
			end
			chk(u_pac_nv_model.mem[10'h007], 32'h5A00C3E1);
			cmd(8'h09, 8'h07, 8'h01, 32'h0, 8'h00, 8'h04, 32'h0);
		end
	endtask
	// Slow store answer while the interpreter waits
	task t_store;
		begin
			lat = 4'h9;
			cmd(8'h09, 8'h2A, 8'h02, 32'hCAFE0042, 8'h00, 8'h64, 32'h0);
			w = u_pac_nv_model.wr_cnt_q;
			cmd(8'h0B, 8'h2A, 8'h02, 32'h0, 8'h00, 8'h64, 32'h0);
			chk(u_pac_nv_model.wr_cnt_q - w, 32'h1);
			chk(u_pac_nv_model.mem[10'h22A], 32'hCAFE0042);
			lat = 4'h1;
		end
	endtask
	// A bad checksum answers with an error and must not load the accumulator
	task t_csum;
		begin
			cmd(8'h0A, 8'h07, 8'h00, 32'h0, 8'h01, 8'h01, 32'h0);
			chk(accu_out, 32'h5A00C3E1);
		end
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = 1'b0;
		t_restore;
		t_axis;
		t_global;
		t_store;
		t_csum;
		t_rerun;
		conclude;
	end
endmodule // tb_pac_cmd_interp
`default_nettype wire
